/* core/mss_pkg.sv */
// Purpose: shared constants for the mesh sleep sync controller
// Assumes: 100 MHz ref_clk; sleep times counted in 1 ms ticks
// Notes: register offsets are word indices on the plain register port
package mss_pkg;
	// ===========================================================
	// register map
	localparam logic [3:0] REG_MODE = 4'h0;
	localparam logic [3:0] REG_SLEEP_PERIOD = 4'h1;
	localparam logic [3:0] REG_WAKE_TIME = 4'h2;
	localparam logic [3:0] REG_OPTIONS = 4'h3;
	localparam logic [3:0] REG_CMD = 4'h4;
	localparam logic [3:0] REG_OP_SLEEP = 4'h5;
	localparam logic [3:0] REG_OP_WAKE = 4'h6;
	localparam logic [3:0] REG_STATUS = 4'h7;
	localparam logic [3:0] REG_MISSED = 4'h8;
	// ===========================================================
	// field values and positions
	localparam logic [3:0] MODE_NORMAL = 4'h0;
	localparam logic [3:0] MODE_SUPPORT = 4'h7;
	localparam logic [3:0] MODE_CYCLIC = 4'h8;
	localparam int OPT_PREFERRED = 0;
	localparam int OPT_NON_COORD = 1;
	localparam int OPT_EARLY_WAKE = 2;
	localparam int OPT_STATUS_FRAMES = 3;
	localparam int CMD_NOMINATE = 0;
	localparam logic [15:0] RST_SLEEP_PERIOD = 16'h00C8;
	localparam logic [15:0] RST_WAKE_TIME = 16'h07D0;
	localparam logic [7:0] MISSED_REQ_LIMIT = 8'h06;
	// ===========================================================
	// timing
	localparam int CLK_HZ = 100_000_000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
	localparam int HOLD_MS = 2000;
	localparam int BTN_WAKE_MS = 30000;
	localparam int PRESS_GAP_MS = 500;
	localparam int LED_FAST_MS = 250;
	localparam int LED_SLOW_MS = 1000;
endpackage : mss_pkg

/* core/mss_ctrl.sv */
// Purpose: sleep synchronisation controller of a sleeping mesh node
// Assumes: radio link delivers decoded sync and request strobes
// Notes: all time counts run on a 1 ms tick derived from ref_clk
//
// Functional notes
// - after reset the node runs awake, non-sleeping, until a mode is set.
// - modes 7 and 8 take part in network sleep synchronisation.
// - mode 8 alternates sleep and wake periods.
// - a received sync sets the operating sleep and wake times.
// - double button press nominates the node as coordinator.
// - coordinator blinks the association led slowly.
// - led blinks while awake and synchronised.
// - one press wakes a sleeping synchronised node.
// - unsynced node sends request on entering sync mode and at each wake start.
// - synced awake node answers a sync request with a sync.
// - sleep support node stays awake always.
// - holding the button 2 s wakes a cyclic sleeper.
// - button wake lasts 30 s and answers requests.
// - changed local settings make node coordinator unless non-coordinator.
// - new settings apply as soon as their sync is sent.
// - a node missing new settings keeps its old ones.
// - early wake option shifts 16 ms per missed cycle from sleep into wake.
// - support node rejects older sync and sends its own.
// - operating sleep and wake queries return the running values.
// - status reports coordinator role.
// - missed count query returns cycles since last sync.
// - status frames pulse just after wake and just before sleep.
// - options bit 0 makes node send sync every wake start.
// - non-coordinator with six missed cycles requests sync at wake.
`timescale 1ns/1ps
module mss_ctrl (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// radio link, receive side
	input wire logic rx_sync,
	input wire logic rx_request,
	input wire logic [15:0] rx_sleep_period,
	input wire logic [15:0] rx_wake_time,
	input wire logic [7:0] rx_generation,
	// radio link, transmit side
	output logic tx_sync,
	output logic tx_request,
	output logic [15:0] tx_sleep_period,
	output logic [15:0] tx_wake_time,
	output logic [7:0] tx_generation,
	// node pins
	input wire logic button_n,
	output logic assoc_led,
	output logic awake,
	output logic status_frame,
	output logic status_is_wake
);
	typedef enum logic [1:0] {
		ST_NORMAL = 2'b00,
		ST_WAKE = 2'b01,
		ST_SLEEP = 2'b10
	} mss_state_e;

	mss_state_e state;
	logic [3:0] mode;
	logic [15:0] cfg_sleep, cfg_wake, op_sleep, op_wake, run_sleep, run_wake;
	logic [3:0] options;
	logic [7:0] missed, generation;
	logic synced, coord, pending_change, btn_awake;
	logic [16:0] tick_cnt;
	logic tick;
	logic [15:0] phase_ms, btn_ms, press_ms, led_ms;
	logic [1:0] presses;
	logic btn_s1, btn_s2, btn_prev;
	logic led_q;
	logic sync_mode, wake_start, go_sleep, send_sync;

	// ===========================================================
	// decode helpers
	function automatic logic is_sync_mode(input logic [3:0] m);
		is_sync_mode = (m == mss_pkg::MODE_SUPPORT) ||
			(m == mss_pkg::MODE_CYCLIC);
	endfunction : is_sync_mode

	function automatic logic [15:0] ms_of(input int v);
		ms_of = 16'(v);
	endfunction : ms_of

	assign sync_mode = is_sync_mode(mode);

	// early wake trades sleep for wake, capped at the whole sleep
	always_comb begin
		logic [15:0] shift;
		shift = 16'h0000;
		if (options[mss_pkg::OPT_EARLY_WAKE]) begin
			shift = {8'h00, missed} << 4;
		end
		if (shift > op_sleep) begin
			shift = op_sleep;
		end
		run_sleep = op_sleep - shift;
		run_wake = op_wake + shift;
	end

	// ===========================================================
	// 1 ms tick
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tick_cnt <= 17'h00000;
			tick <= 1'b0;
		end else if (tick_cnt == 17'(mss_pkg::TICK_CYC - 1)) begin
			tick_cnt <= 17'h00000;
			tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 17'h00001;
			tick <= 1'b0;
		end
	end

	// ===========================================================
	// button: two-flop sync, press counting and hold timing
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			btn_s1 <= 1'b0;
			btn_s2 <= 1'b0;
			btn_prev <= 1'b0;
		end else begin
			btn_s1 <= ~button_n;
			btn_s2 <= btn_s1;
			btn_prev <= btn_s2;
		end
	end

	// presses within the gap window are counted together
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			presses <= 2'h0;
			press_ms <= 16'h0000;
		end else if (btn_s2 && !btn_prev) begin
			presses <= (presses == 2'h3) ? presses : presses + 2'h1;
			press_ms <= 16'h0000;
		end else if (presses != 2'h0 && tick) begin
			if (press_ms == ms_of(mss_pkg::PRESS_GAP_MS)) begin
				presses <= 2'h0;
			end else begin
				press_ms <= press_ms + 16'h0001;
			end
		end
	end

	// hold timer counts only while the button stays down
	logic [15:0] hold_ms;
	logic hold_wake, single_wake, double_press;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			hold_ms <= 16'h0000;
		end else if (!btn_s2) begin
			hold_ms <= 16'h0000;
		end else if (tick && hold_ms != 16'hFFFF) begin
			hold_ms <= hold_ms + 16'h0001;
		end
	end
	assign hold_wake = btn_s2 && hold_ms == ms_of(mss_pkg::HOLD_MS);
	assign single_wake = presses == 2'h1 && tick &&
		press_ms == ms_of(mss_pkg::PRESS_GAP_MS) && synced;
	assign double_press = presses == 2'h2 && tick &&
		press_ms == ms_of(mss_pkg::PRESS_GAP_MS);

	// ===========================================================
	// register writes and the coordinator role
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode <= mss_pkg::MODE_NORMAL;
			cfg_sleep <= mss_pkg::RST_SLEEP_PERIOD;
			cfg_wake <= mss_pkg::RST_WAKE_TIME;
			options <= 4'h0;
		end else if (reg_wr) begin
			case (reg_addr)
				mss_pkg::REG_MODE: mode <= reg_wdata[3:0];
				mss_pkg::REG_SLEEP_PERIOD: cfg_sleep <= reg_wdata;
				mss_pkg::REG_WAKE_TIME: cfg_wake <= reg_wdata;
				mss_pkg::REG_OPTIONS: options <= reg_wdata[3:0];
				default: ;
			endcase
		end
	end

	// settings change waits for the next sync sent, at wake start or in a reply
	logic set_wr;
	assign set_wr = reg_wr && (reg_addr == mss_pkg::REG_SLEEP_PERIOD ||
		reg_addr == mss_pkg::REG_WAKE_TIME);
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pending_change <= 1'b0;
			coord <= 1'b0;
		end else begin
			if (set_wr && !options[mss_pkg::OPT_NON_COORD] &&
				reg_wdata != (reg_addr == mss_pkg::REG_SLEEP_PERIOD ?
				op_sleep : op_wake)) begin
				pending_change <= 1'b1;
				coord <= 1'b1;
			end else if (send_sync) begin
				pending_change <= 1'b0;
			end
			if ((double_press || (reg_wr && reg_addr == mss_pkg::REG_CMD &&
				reg_wdata[mss_pkg::CMD_NOMINATE])) &&
				!options[mss_pkg::OPT_NON_COORD]) begin
				coord <= 1'b1;
			end else if (rx_sync && rx_generation > generation &&
				!pending_change && !set_wr) begin
				coord <= 1'b0; // a newer coordinator outranks us
			end
		end
	end

	// ===========================================================
	// sleep and wake sequencing
	assign wake_start = (state == ST_SLEEP && tick &&
		phase_ms >= run_sleep) || (state == ST_SLEEP && (hold_wake ||
		single_wake)) ||
		(state == ST_SLEEP && mode != mss_pkg::MODE_CYCLIC);
	assign go_sleep = state == ST_WAKE && tick && phase_ms >= run_wake &&
		!btn_awake && mode == mss_pkg::MODE_CYCLIC;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_NORMAL;
			phase_ms <= 16'h0000;
		end else if (!sync_mode) begin
			state <= ST_NORMAL;
			phase_ms <= 16'h0000;
		end else if (state == ST_NORMAL || wake_start) begin
			state <= ST_WAKE;
			phase_ms <= 16'h0000;
		end else if (go_sleep) begin
			state <= ST_SLEEP;
			phase_ms <= 16'h0000;
		end else if (rx_sync && rx_generation >= generation &&
			state == ST_WAKE && !coord) begin
			phase_ms <= 16'h0000; // realign to the coordinator
		end else if (tick) begin
			phase_ms <= phase_ms + 16'h0001;
		end
	end

	// button wake holds the node up for a fixed time
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			btn_awake <= 1'b0;
			btn_ms <= 16'h0000;
		end else if (hold_wake || single_wake) begin
			btn_awake <= 1'b1;
			btn_ms <= 16'h0000;
		end else if (btn_awake && tick) begin
			if (btn_ms == ms_of(mss_pkg::BTN_WAKE_MS) - 16'h0001) begin
				btn_awake <= 1'b0;
			end
			btn_ms <= btn_ms + 16'h0001;
		end
	end

	// ===========================================================
	// sync state, operating times and missed count
	logic newer_rx, older_rx;
	assign newer_rx = rx_sync && rx_generation >= generation;
	assign older_rx = rx_sync && rx_generation < generation && synced;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			op_sleep <= mss_pkg::RST_SLEEP_PERIOD;
			op_wake <= mss_pkg::RST_WAKE_TIME;
			generation <= 8'h00;
			synced <= 1'b0;
		end else if (send_sync && pending_change) begin
			op_sleep <= cfg_sleep;
			op_wake <= cfg_wake;
			generation <= generation + 8'h01;
			synced <= 1'b1;
		end else if (newer_rx && sync_mode && !pending_change) begin
			op_sleep <= rx_sleep_period;
			op_wake <= rx_wake_time;
			generation <= rx_generation;
			synced <= 1'b1;
		end else if (!synced && state == ST_NORMAL) begin
			op_sleep <= cfg_sleep; // own period until synced
			op_wake <= cfg_wake;
		end
	end // missed updates leave op values as they were

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			missed <= 8'h00;
		end else if (newer_rx) begin
			missed <= 8'h00;
		end else if (wake_start && missed != 8'hFF) begin
			missed <= missed + 8'h01;
		end
	end

	// ===========================================================
	// link transmit: syncs, replies and requests
	logic ask;
	assign send_sync = sync_mode && synced | pending_change &&
		((wake_start && (coord || options[mss_pkg::OPT_PREFERRED])) ||
		(rx_request && state == ST_WAKE) ||
		(older_rx && mode == mss_pkg::MODE_SUPPORT));
	assign ask = sync_mode && ((wake_start || state == ST_NORMAL) &&
		!synced || wake_start && options[mss_pkg::OPT_NON_COORD] &&
		missed >= mss_pkg::MISSED_REQ_LIMIT - 8'h01);

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_sync <= 1'b0;
			tx_request <= 1'b0;
			tx_sleep_period <= 16'h0000;
			tx_wake_time <= 16'h0000;
			tx_generation <= 8'h00;
		end else begin
			tx_sync <= send_sync;
			tx_request <= ask && !send_sync;
			if (send_sync) begin
				tx_sleep_period <= pending_change ? cfg_sleep : op_sleep;
				tx_wake_time <= pending_change ? cfg_wake : op_wake;
				tx_generation <= pending_change ? generation + 8'h01 :
					generation;
			end
		end
	end

	// ===========================================================
	// led, awake pin and status frames
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			led_ms <= 16'h0000;
			led_q <= 1'b0;
		end else if (!(coord || synced) || state == ST_SLEEP) begin
			led_ms <= 16'h0000;
			led_q <= 1'b0;
		end else if (tick) begin
			if (led_ms >= ms_of(coord ? mss_pkg::LED_SLOW_MS :
				mss_pkg::LED_FAST_MS)) begin
				led_ms <= 16'h0000;
				led_q <= ~led_q;
			end else begin
				led_ms <= led_ms + 16'h0001;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			assoc_led <= 1'b0;
			awake <= 1'b1;
			status_frame <= 1'b0;
			status_is_wake <= 1'b0;
		end else begin
			assoc_led <= led_q;
			awake <= state != ST_SLEEP || wake_start; // up with wake frame
			status_frame <= options[mss_pkg::OPT_STATUS_FRAMES] &&
				(wake_start || go_sleep);
			if (wake_start || go_sleep) begin
				status_is_wake <= wake_start;
			end
		end
	end

	// ===========================================================
	// register reads, data one cycle after the strobe
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				mss_pkg::REG_MODE: reg_rdata <= {12'h000, mode};
				mss_pkg::REG_SLEEP_PERIOD: reg_rdata <= cfg_sleep;
				mss_pkg::REG_WAKE_TIME: reg_rdata <= cfg_wake;
				mss_pkg::REG_OPTIONS: reg_rdata <= {12'h000, options};
				mss_pkg::REG_OP_SLEEP: reg_rdata <= run_sleep;
				mss_pkg::REG_OP_WAKE: reg_rdata <= run_wake;
				mss_pkg::REG_STATUS: reg_rdata <= {10'h000, pending_change,
					btn_awake, state == ST_SLEEP, synced, coord,
					sync_mode};
				mss_pkg::REG_MISSED: reg_rdata <= {8'h00, missed};
				default: reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end
endmodule : mss_ctrl

/* test/mss_ctrl_checker.sv */
// Purpose: port assertions for the sleep sync controller
// Assumes: one ref_clk domain, sys_rst async active high
// Notes: helper flags mirror the mode and the syncs seen at the ports
`timescale 1ns/1ps
module mss_ctrl_checker (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// radio link
	input wire logic rx_sync,
	input wire logic rx_request,
	input wire logic [7:0] rx_generation,
	input wire logic tx_sync,
	input wire logic tx_request,
	input wire logic [15:0] tx_sleep_period,
	input wire logic [15:0] tx_wake_time,
	input wire logic [7:0] tx_generation,
	// node pins
	input wire logic awake,
	input wire logic status_frame
);
	logic [3:0] mode_q;
	logic got_sync;
	logic [7:0] gen_q;
	// ===========================================================
	// helper state
	// mirror of the mode register as written
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode_q <= 4'h0;
		end else if (reg_wr && reg_addr == mss_pkg::REG_MODE) begin
			mode_q <= reg_wdata[3:0];
		end
	end
	// newest generation heard; older ones must not win
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			got_sync <= 1'b0;
			gen_q <= 8'h00;
		end else if (rx_sync && mode_q == mss_pkg::MODE_SUPPORT) begin
			got_sync <= 1'b1;
			if (!got_sync || rx_generation > gen_q) begin
				gen_q <= rx_generation;
			end
		end
	end
	// ===========================================================
	// assertions
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	a_rdata_gap: assert property (!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data outside its slot");
	a_tx_hold: assert property (!tx_sync |-> $stable(tx_sleep_period)
		&& $stable(tx_wake_time) && $stable(tx_generation))
		else $error("sync fields moved without a sync");
	a_req_pulse: assert property (tx_request |=> !tx_request)
		else $error("request longer than one cycle");
	a_stay_awake: assert property (mode_q != mss_pkg::MODE_CYCLIC
		|-> awake)
		else $error("non cyclic node asleep");
	a_normal_quiet: assert property (mode_q != mss_pkg::MODE_SUPPORT
		&& mode_q != mss_pkg::MODE_CYCLIC |-> !tx_sync && !tx_request)
		else $error("normal node sent sync traffic");
	a_reply_sync: assert property (mode_q == mss_pkg::MODE_SUPPORT
		&& got_sync && rx_request |=> tx_sync)
		else $error("request not answered");
	a_reject_old: assert property (mode_q == mss_pkg::MODE_SUPPORT
		&& got_sync && rx_sync && rx_generation < gen_q |-> ##[1:4] tx_sync)
		else $error("older sync not answered");
	a_frame_awake: assert property (status_frame |-> awake)
		else $error("status frame while asleep");
	a_quiet_asleep: assert property (!awake |-> !tx_sync)
		else $error("sync sent while asleep");
endmodule : mss_ctrl_checker

bind mss_ctrl mss_ctrl_checker chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_sync(rx_sync),
	.rx_request(rx_request), .rx_generation(rx_generation),
	.tx_sync(tx_sync), .tx_request(tx_request),
	.tx_sleep_period(tx_sleep_period), .tx_wake_time(tx_wake_time),
	.tx_generation(tx_generation), .awake(awake),
	.status_frame(status_frame));

/* test/mss_peer.sv */
// Purpose: peer mesh node on the radio side
// Assumes: decoded frames arrive as one-cycle strobes
// Notes: fields are scrambled once a frame ends
`timescale 1ns/1ps
module mss_peer (
	// clock
	input wire logic ref_clk,
	// frames towards the node
	output logic rx_sync,
	output logic rx_request,
	output logic [15:0] rx_sleep_period,
	output logic [15:0] rx_wake_time,
	output logic [7:0] rx_generation,
	// frames from the node
	input wire logic tx_sync,
	input wire logic [15:0] tx_sleep_period,
	input wire logic [7:0] tx_generation
);
	int heard = 0;
	logic [15:0] heard_sp;
	logic [7:0] heard_gen;
	// idle radio
	initial begin
		rx_sync = 1'b0;
		rx_request = 1'b0;
		rx_sleep_period = 16'h0000;
		rx_wake_time = 16'h0000;
		rx_generation = 8'h00;
	end
	// callers keep cycle lengths in whole ratios
	task automatic send_sync(input logic [15:0] sp, input logic [15:0] wt,
		input logic [7:0] gen);
		@(posedge ref_clk);
		rx_sync <= 1'b1;
		rx_sleep_period <= sp;
		rx_wake_time <= wt;
		rx_generation <= gen;
		@(posedge ref_clk);
		rx_sync <= 1'b0;
		rx_sleep_period <= ~sp;
		rx_wake_time <= ~wt;
		rx_generation <= ~gen;
	endtask : send_sync
	// unsynced neighbour asking for a sync
	task automatic send_request();
		@(posedge ref_clk);
		rx_request <= 1'b1;
		@(posedge ref_clk);
		rx_request <= 1'b0;
	endtask : send_request
	// log every sync the node sends
	always @(posedge ref_clk) begin
		if (tx_sync === 1'b1) begin
			heard++;
			heard_sp <= tx_sleep_period;
			heard_gen <= tx_generation;
		end
	end
endmodule : mss_peer

/* test/tb_mss_ctrl.sv */
// Purpose: self-checking bench for the sleep sync controller
// Assumes: peer model drives the radio side
// Notes: ms timers are too long to run here; no test or assertion covers them
`timescale 1ns/1ps
`define CHK(n, e, g) check(n, 16'(e), 16'(g))
module tb_mss_ctrl;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	// button left released: its timings run to seconds
	logic button_n = 1'b1;
	logic [15:0] reg_rdata, rv;
	logic rx_sync, rx_request, tx_sync, tx_request, assoc_led, awake;
	logic status_frame, status_is_wake;
	logic [15:0] rx_sleep_period, rx_wake_time, tx_sleep_period, tx_wake_time;
	logic [7:0] rx_generation, tx_generation;
	int mismatches = 0;
	int num_checks = 0;
	int seen;
	// 100 MHz
	always #5 ref_clk = ~ref_clk;
	mss_ctrl dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .rx_sync(rx_sync), .rx_request(rx_request),
		.rx_sleep_period(rx_sleep_period), .rx_wake_time(rx_wake_time),
		.rx_generation(rx_generation), .tx_sync(tx_sync),
		.tx_request(tx_request), .tx_sleep_period(tx_sleep_period),
		.tx_wake_time(tx_wake_time), .tx_generation(tx_generation),
		.button_n(button_n), .assoc_led(assoc_led), .awake(awake),
		.status_frame(status_frame), .status_is_wake(status_is_wake));
	mss_peer peer (.ref_clk(ref_clk), .rx_sync(rx_sync),
		.rx_request(rx_request), .rx_sleep_period(rx_sleep_period),
		.rx_wake_time(rx_wake_time), .rx_generation(rx_generation),
		.tx_sync(tx_sync), .tx_sleep_period(tx_sleep_period),
		.tx_generation(tx_generation));
	task automatic check(input string n, input logic [15:0] e, g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : check
	// one-cycle strobes, released on the next edge
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask : rd
	task automatic t_reset();
		rd(mss_pkg::REG_MODE);
		`CHK("mode", mss_pkg::MODE_NORMAL, rv);
		rd(mss_pkg::REG_SLEEP_PERIOD);
		`CHK("sleep cfg", mss_pkg::RST_SLEEP_PERIOD, rv);
		rd(4'hF);
		`CHK("unmapped", 16'h0000, rv);
		`CHK("awake", 1'b1, awake);
		`CHK("led off", 1'b0, assoc_led);
		`CHK("no frame", 1'b0, status_frame);
		`CHK("frame kind", 1'b0, status_is_wake);
		$display("test reset done");
	endtask : t_reset
	task automatic t_sync();
		wr(mss_pkg::REG_MODE, 16'(mss_pkg::MODE_SUPPORT));
		@(posedge ref_clk);
		#1;
		`CHK("first request", 1'b1, tx_request);
		peer.send_sync(16'h0064, 16'h01F4, 8'h02);
		wr(mss_pkg::REG_OP_SLEEP, 16'h1234);
		rd(mss_pkg::REG_OP_SLEEP);
		`CHK("op sleep", 16'h0064, rv);
		rd(mss_pkg::REG_OP_WAKE);
		`CHK("op wake", 16'h01F4, rv);
		rd(mss_pkg::REG_STATUS);
		`CHK("status", 16'h0005, rv & 16'h000D);
		rd(mss_pkg::REG_MISSED);
		`CHK("missed", 16'h0000, rv);
		`CHK("support awake", 1'b1, awake);
		$display("test sync done");
	endtask : t_sync
	task automatic t_reply();
		peer.send_request();
		#1;
		`CHK("reply", 1'b1, tx_sync);
		`CHK("reply sleep", 16'h0064, tx_sleep_period);
		`CHK("reply wake", 16'h01F4, tx_wake_time);
		@(posedge ref_clk);
		#1;
		`CHK("reply end", 1'b0, tx_sync);
		$display("test reply done");
	endtask : t_reply
	task automatic t_reject();
		seen = peer.heard;
		peer.send_sync(16'h0AAA, 16'h0BBB, 8'h01);
		repeat (5) @(posedge ref_clk);
		`CHK("reject sent", 1'b1, peer.heard > seen);
		`CHK("reject gen", 8'h02, peer.heard_gen);
		`CHK("reject sleep", 16'h0064, peer.heard_sp);
		rd(mss_pkg::REG_OP_SLEEP);
		`CHK("kept sleep", 16'h0064, rv);
		$display("test reject done");
	endtask : t_reject
	task automatic t_change();
		// non-coordinator option refuses both the change and nomination
		wr(mss_pkg::REG_OPTIONS, 16'h0002);
		wr(mss_pkg::REG_SLEEP_PERIOD, 16'h0100);
		wr(mss_pkg::REG_CMD, 16'h0001);
		rd(mss_pkg::REG_STATUS);
		`CHK("no pending", 16'h0000, rv & 16'h0020);
		`CHK("no nominate", 16'h0000, rv & 16'h0002);
		wr(mss_pkg::REG_OPTIONS, 16'h0000);
		wr(mss_pkg::REG_CMD, 16'h0001);
		rd(mss_pkg::REG_STATUS);
		`CHK("coordinator", 16'h0002, rv & 16'h0002);
		wr(mss_pkg::REG_SLEEP_PERIOD, 16'h0100);
		rd(mss_pkg::REG_STATUS);
		`CHK("pending", 16'h0020, rv & 16'h0020);
		rd(mss_pkg::REG_OP_SLEEP);
		`CHK("op before send", 16'h0064, rv);
		// the next sync sent carries the new settings and applies them
		peer.send_request();
		#1;
		`CHK("new sync", 1'b1, tx_sync);
		`CHK("new sleep", 16'h0100, tx_sleep_period);
		`CHK("new gen", 8'h03, tx_generation);
		rd(mss_pkg::REG_OP_SLEEP);
		`CHK("op after send", 16'h0100, rv);
		rd(mss_pkg::REG_STATUS);
		`CHK("sent", 16'h0000, rv & 16'h0020);
		$display("test change done");
	endtask : t_change
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report
	// main sequence
	initial begin
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_sync();
		t_reply();
		t_reject();
		t_change();
		final_report();
	end
	// hang guard, far past the sixty or so cycles the tests need
	initial begin
		repeat (5000) @(posedge ref_clk);
		mismatches++;
		final_report();
	end
endmodule : tb_mss_ctrl
